// ---- dlq_top.sv ----
`timescale 1ns/100ps
`include "dlq_map.svh"
module dlq_top import dlq_pkg::*; #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // receive link bits
  input  wire logic        rx_bit_valid,
  input  wire logic        rx_bit,
  // transmit link bits
  input  wire logic        tx_bit_req,
  output logic             tx_bit,
  // per-second report data
  input  wire logic        report_tick,
  input  wire logic [15:0] report_word,
  // interrupt
  output logic             link_irq
);
  //////////////////////////////////////////////////////////////////////////////
  // crc step, shared by both directions
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = (c >> 1) ^ (((c[0] ^ b) == 1'b1) ? `DLQ_CRC_POLY : 16'h0000);
  endfunction : crc_step

  localparam logic [AW:0] FULLN = (AW+1)'(DEPTH);

  logic [7:0]       tx_ctl_r, irq_en_r, bom_r, rep_lo_r, rep_hi_r;
  logic [5:0]       level_r;
  logic             ralm_r, full_irq_r, eof_irq_r, ovr_r, ovr_seen_r, idle_irq_r;
  logic [7:0]       rxq [DEPTH];
  logic [DEPTH-1:0] rq_sf_r;
  logic [AW-1:0]    rq_wp_r, rq_rp_r, tq_wp_r, tq_rp_r;
  logic [AW:0]      rq_tot_r, rq_sfn_r, rq_dist, tq_n_r, tot_nxt;
  logic             found, pop, push, push_sf, full, done, rd_acc, wr_acc;
  logic [7:0]       push_data, ovr_byte;
  dlq_txe_s         txq [DEPTH];

  //////////////////////////////////////////////////////////////////////////////
  // apb: answer one cycle after setup, effects at the access edge
  assign done   = psel && penable && pready;
  assign rd_acc = done && !pwrite;
  assign wr_acc = done && pwrite;

  // queue count: bytes up to first status byte, else all bytes
  always_comb begin
    rq_dist = '0;
    found   = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if (!found && i < rq_tot_r && rq_sf_r[AW'(rq_rp_r + AW'(i))]) begin
        found   = 1'b1;
        rq_dist = (AW+1)'(i + 1);
      end
    end
  end

  // read data mux, registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `DLQ_A_IRQ:    prdata[7:0] <= {1'b0, idle_irq_r, ovr_r, eof_irq_r, full_irq_r, 3'h0};
          `DLQ_A_QSTAT:  prdata[7:0] <= {(rq_sfn_r != 0), found ? rq_dist : rq_tot_r};
          `DLQ_A_RXDATA: prdata[7:0] <= rxq[rq_rp_r];
          `DLQ_A_TXCTL:  prdata[7:0] <= tx_ctl_r;
          `DLQ_A_IRQEN:  prdata[7:0] <= irq_en_r;
          `DLQ_A_LEVEL:  prdata[7:0] <= {2'h0, level_r};
          `DLQ_A_BOM:    prdata[7:0] <= bom_r;
          `DLQ_A_RALM:   prdata[7:0] <= {7'h00, ralm_r};
          `DLQ_A_REPLO:  prdata[7:0] <= rep_lo_r;
          `DLQ_A_REPHI:  prdata[7:0] <= rep_hi_r;
          `DLQ_A_TXDATA: prdata[7:0] <= {1'b0, tq_n_r};
          default:       pslverr     <= 1'b1;
        endcase
      end
    end
  end

  // control registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ctl_r <= `DLQ_R_CTL;
      irq_en_r <= `DLQ_R_CTL;
      bom_r    <= `DLQ_R_CTL;
      level_r  <= `DLQ_R_LEVEL;
      ralm_r   <= 1'b0;
    end else if (wr_acc) begin
      case (paddr)
        `DLQ_A_TXCTL: tx_ctl_r <= pwdata[7:0];
        `DLQ_A_IRQEN: irq_en_r <= pwdata[7:0];
        `DLQ_A_LEVEL: level_r  <= pwdata[5:0];
        `DLQ_A_BOM:   bom_r    <= pwdata[7:0];
        `DLQ_A_RALM:  ralm_r   <= pwdata[0];
        default:      ralm_r   <= ralm_r;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive deframer
  logic [3:0]  rx_ones_r;
  logic [6:0]  rx_dly_r;
  logic [2:0]  rx_dn_r, rx_bc_r;
  logic [1:0]  rx_hn_r;
  logic [7:0]  rx_byte_r, rx_h1_r, rx_h2_r, rx_nb;
  logic [15:0] rx_crc_r;
  logic        rx_inf_r, rx_disc_r, is_flag, is_abort, is_data, emit;
  dlq_sf_s     sf;

  assign is_flag  = rx_bit_valid && !rx_bit && rx_ones_r == 4'h6;
  assign is_abort = rx_bit_valid && rx_bit && rx_ones_r == 4'h6;
  // a zero after five ones is dropped here
  assign is_data  = rx_bit_valid && rx_ones_r < 4'h6 && !(!rx_bit && rx_ones_r == 4'h5);
  assign emit     = is_data && rx_inf_r && rx_dn_r == 3'h7;
  assign rx_nb    = {rx_dly_r[0], rx_byte_r[7:1]};

  // status-of-frame byte and queue write request
  always_comb begin
    sf           = '0;
    sf.bad_crc   = rx_hn_r != 2'h2 || rx_crc_r != `DLQ_CRC_GOOD;
    sf.abort     = is_abort;
    sf.bad_count = rx_bc_r != 3'h0;
    push_sf      = (is_flag || is_abort) && rx_inf_r && rx_hn_r != 2'h0;
    push         = !rx_disc_r && (push_sf || (emit && rx_bc_r == 3'h7 && rx_hn_r == 2'h2));
    push_data    = push_sf ? sf : rx_h2_r;
    ovr_byte     = push_sf ? (push_data | 8'h20) : 8'h20;
  end

  // bit delay keeps flag bits out of the data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ones_r <= 4'h0;
      rx_dly_r  <= 7'h00;
      rx_dn_r   <= 3'h0;
      rx_bc_r   <= 3'h0;
      rx_hn_r   <= 2'h0;
      rx_byte_r <= 8'h00;
      rx_h1_r   <= 8'h00;
      rx_h2_r   <= 8'h00;
      rx_crc_r  <= `DLQ_CRC_INIT;
      rx_inf_r  <= 1'b0;
      rx_disc_r <= 1'b0;
    end else begin
      if (rx_bit_valid)
        rx_ones_r <= !rx_bit ? 4'h0 : (rx_ones_r == 4'hF ? 4'hF : rx_ones_r + 4'h1);
      if (is_flag) begin
        rx_inf_r <= 1'b1;
        rx_dn_r  <= 3'h0;
        rx_bc_r  <= 3'h0;
        rx_hn_r  <= 2'h0;
        rx_crc_r <= `DLQ_CRC_INIT;
        if (!ovr_r)
          rx_disc_r <= 1'b0;
      end else if (is_abort || (rx_bit_valid && rx_ones_r > 4'h6)) begin
        rx_inf_r <= 1'b0;
      end else if (is_data && rx_inf_r) begin
        rx_dly_r <= {rx_bit, rx_dly_r[6:1]};
        if (rx_dn_r != 3'h7)
          rx_dn_r <= rx_dn_r + 3'h1;
      end
      if (emit) begin
        rx_crc_r  <= crc_step(rx_crc_r, rx_dly_r[0]);
        rx_byte_r <= rx_nb;
        rx_bc_r   <= rx_bc_r + 3'h1;
        if (rx_bc_r == 3'h7) begin
          rx_h1_r <= rx_nb;  // last two bytes held back as check sequence
          rx_h2_r <= rx_h1_r;
          if (rx_hn_r != 2'h2)
            rx_hn_r <= rx_hn_r + 2'h1;
        end
      end
      if (push && full)
        rx_disc_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive queue
  assign pop     = rd_acc && paddr == `DLQ_A_RXDATA && rq_tot_r != 0;
  assign full    = rq_tot_r == FULLN && !pop;
  assign tot_nxt = rq_tot_r + (AW+1)'(push && !full) - (AW+1)'(pop);

  always_ff @(posedge pclk) begin
    if (push && full)
      rxq[rq_wp_r - AW'(1)] <= ovr_byte;
    else if (push)
      rxq[rq_wp_r] <= push_data;
  end

  // pointers and counts; read and write in one cycle both count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rq_wp_r  <= '0;
      rq_rp_r  <= '0;
      rq_tot_r <= '0;
      rq_sfn_r <= '0;
      rq_sf_r  <= '0;
    end else begin
      rq_tot_r <= tot_nxt;
      rq_sfn_r <= rq_sfn_r + (AW+1)'(push && (full ? !rq_sf_r[rq_wp_r - AW'(1)] : push_sf))
                - (AW+1)'(pop && rq_sf_r[rq_rp_r]);
      if (pop) begin
        rq_rp_r          <= rq_rp_r + AW'(1);
        rq_sf_r[rq_rp_r] <= 1'b0;
      end
      if (push && full) begin
        rq_sf_r[rq_wp_r - AW'(1)] <= 1'b1;
      end else if (push) begin
        rq_sf_r[rq_wp_r] <= push_sf;
        rq_wp_r          <= rq_wp_r + AW'(1);
      end
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_irq_r <= 1'b0;
      eof_irq_r  <= 1'b0;
      idle_irq_r <= 1'b0;
      ovr_r      <= 1'b0;
      ovr_seen_r <= 1'b0;
    end else begin
      if (rd_acc && paddr == `DLQ_A_IRQ) begin
        full_irq_r <= 1'b0;
        eof_irq_r  <= 1'b0;
        idle_irq_r <= 1'b0;
        ovr_seen_r <= ovr_r;
      end
      if (pop && ovr_seen_r) begin
        ovr_r      <= 1'b0;
        ovr_seen_r <= 1'b0;
      end
      if (level_r != 6'h00 && tot_nxt == (AW+1)'(level_r) && rq_tot_r != tot_nxt)
        full_irq_r <= 1'b1;
      if (push && (push_sf || full))
        eof_irq_r <= 1'b1;
      if (rx_bit_valid && rx_bit && rx_ones_r == 4'hE)
        idle_irq_r <= 1'b1;
      if (push && full) begin
        ovr_r      <= 1'b1;
        ovr_seen_r <= 1'b0;
      end
    end
  end

  // interrupt pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      link_irq <= 1'b0;
    else
      link_irq <= (full_irq_r && irq_en_r[`DLQ_B_FULL]) || (ovr_r && irq_en_r[`DLQ_B_OVR])
                  || eof_irq_r || idle_irq_r;
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit queue and report store
  logic [63:0] prm_r, prm_sh;
  logic [1:0]  prm_sec_r;
  logic        prm_pend_r, tq_push, tq_pop;
  dlq_tx_e     st_r;
  logic [3:0]  pidx_r, pat_r;

  assign tq_push = wr_acc && paddr == `DLQ_A_TXDATA && tq_n_r != FULLN;

  always_ff @(posedge pclk) begin
    if (tq_push)
      txq[tq_wp_r] <= pwdata[`DLQ_B_LAST:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tq_wp_r <= '0;
      tq_rp_r <= '0;
      tq_n_r  <= '0;
    end else begin
      tq_wp_r <= tq_wp_r + AW'(tq_push);
      tq_rp_r <= tq_rp_r + AW'(tq_pop);
      tq_n_r  <= tq_n_r + (AW+1)'(tq_push) - (AW+1)'(tq_pop);
    end
  end

  // newest second goes to the front of the report
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_lo_r   <= 8'h00;
      rep_hi_r   <= 8'h00;
      prm_r      <= 64'h0;
      prm_sec_r  <= 2'h0;
      prm_pend_r <= 1'b0;
    end else begin
      if (report_tick) begin
        rep_lo_r <= report_word[7:0];
        rep_hi_r <= report_word[15:8];
        prm_r    <= {report_word[7:0], report_word[15:8], prm_r[63:16]};
        if (prm_sec_r != 2'h3)
          prm_sec_r <= prm_sec_r + 2'h1;
      end
      if (report_tick && tx_ctl_r[`DLQ_B_PRMEN] && prm_sec_r >= 2'h2)
        prm_pend_r <= 1'b1;
      else if (tx_bit_req && st_r == DLQ_TX_IDLE && tx_ctl_r[`DLQ_B_TXEN] && !ralm_r && !bom_r[`DLQ_B_BOMEN])
        prm_pend_r <= 1'b0;  // the framer takes the pending report as it opens a frame
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit framer
  logic [15:0] sh_r, tcrc_nxt, bom_pat;
  logic [15:0] tcrc_r;
  logic [4:0]  sn_r;
  logic [2:0]  tones_r;
  logic        src_prm_r, last_r, stuff, hdlc, nb_last, have;
  logic [7:0]  nb;

  assign bom_pat  = {1'b0, bom_r[5:0], 1'b0, 8'hFF};
  assign hdlc     = tx_ctl_r[`DLQ_B_TXEN] && (st_r != DLQ_TX_IDLE
                    || (!ralm_r && !bom_r[`DLQ_B_BOMEN]));
  assign stuff    = st_r != DLQ_TX_IDLE && tones_r == 3'h5;
  assign tcrc_nxt = crc_step(tcrc_r, sh_r[0]);
  assign prm_sh   = prm_r << {pidx_r - 4'h3, 3'h0};
  assign have     = src_prm_r || tq_n_r != 0;
  assign tq_pop   = tx_bit_req && hdlc && !stuff && sn_r == 5'h1 && have && !src_prm_r
                    && (st_r == DLQ_TX_OPEN || (st_r == DLQ_TX_DATA && !last_r));

  // next user byte: report header and seconds, or host queue
  always_comb begin
    case (pidx_r)
      4'h0:    nb = `DLQ_HDR0;
      4'h1:    nb = `DLQ_HDR1;
      4'h2:    nb = `DLQ_HDR2;
      default: nb = prm_sh[63:56];
    endcase
    nb_last = pidx_r == `DLQ_PRM_LAST;
    if (!src_prm_r) begin
      nb      = txq[tq_rp_r].data;
      nb_last = txq[tq_rp_r].last;
    end
  end

  // one bit per request from the framer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= DLQ_TX_IDLE;
      sh_r      <= 16'hFFFF;
      sn_r      <= 5'h0;
      tcrc_r    <= `DLQ_CRC_INIT;
      tones_r   <= 3'h0;
      pidx_r    <= 4'h0;
      pat_r     <= 4'h0;
      src_prm_r <= 1'b0;
      last_r    <= 1'b0;
      tx_bit    <= 1'b1;
    end else if (tx_bit_req) begin
      pat_r <= pat_r + 4'h1;
      if (!tx_ctl_r[`DLQ_B_TXEN])
        st_r <= DLQ_TX_IDLE;
      if (ralm_r && st_r == DLQ_TX_IDLE)
        tx_bit <= 1'(`DLQ_ALARM >> pat_r);
      else if (!hdlc)
        tx_bit <= bom_r[`DLQ_B_BOMEN] && tx_ctl_r[`DLQ_B_TXEN] ? bom_pat[pat_r] : 1'b1;
      else if (st_r == DLQ_TX_IDLE) begin
        tx_bit <= 1'b1;  // idle code between frames
        if (prm_pend_r || tq_n_r != 0) begin
          st_r      <= DLQ_TX_OPEN;
          sh_r      <= {8'hFF, `DLQ_FLAG};
          sn_r      <= 5'h8;
          src_prm_r <= prm_pend_r;
          pidx_r    <= 4'h0;
          tcrc_r    <= `DLQ_CRC_INIT;
        end
      end else if (stuff) begin
        tx_bit  <= 1'b0;
        tones_r <= 3'h0;
      end else begin
        tx_bit  <= sh_r[0];
        sh_r    <= {1'b1, sh_r[15:1]};
        sn_r    <= sn_r - 5'h1;
        tones_r <= (st_r == DLQ_TX_OPEN || st_r == DLQ_TX_CLOSE || !sh_r[0]) ? 3'h0 : tones_r + 3'h1;
        if (st_r == DLQ_TX_DATA)
          tcrc_r <= tcrc_nxt;
        if (sn_r == 5'h1) begin
          case (st_r)
            DLQ_TX_OPEN, DLQ_TX_DATA: begin
              if (st_r == DLQ_TX_DATA && last_r) begin
                st_r <= DLQ_TX_CRC;
                sh_r <= ~tcrc_nxt;
                sn_r <= 5'h10;
              end else if (have) begin
                st_r   <= DLQ_TX_DATA;
                sh_r   <= {8'hFF, nb};
                sn_r   <= 5'h8;
                last_r <= nb_last;
                pidx_r <= pidx_r + 4'h1;
              end else begin
                st_r <= DLQ_TX_CLOSE;  // underrun: abort
                sh_r <= {8'hFF, `DLQ_ABORT};
                sn_r <= 5'h8;
              end
            end
            DLQ_TX_CRC: begin
              st_r <= DLQ_TX_CLOSE;
              sh_r <= {8'hFF, `DLQ_FLAG};
              sn_r <= 5'h8;
            end
            default: st_r <= DLQ_TX_IDLE;
          endcase
        end
      end
    end
  end
endmodule : dlq_top

// ---- dlq_map.svh ----
`ifndef DLQ_MAP_SVH
`define DLQ_MAP_SVH

// register byte addresses
`define DLQ_A_IRQ    8'h00
`define DLQ_A_QSTAT  8'h04
`define DLQ_A_RXDATA 8'h08
`define DLQ_A_TXCTL  8'h0C
`define DLQ_A_IRQEN  8'h10
`define DLQ_A_LEVEL  8'h14
`define DLQ_A_BOM    8'h18
`define DLQ_A_RALM   8'h1C
`define DLQ_A_REPLO  8'h20
`define DLQ_A_REPHI  8'h24
`define DLQ_A_TXDATA 8'h28
// field positions
`define DLQ_B_FULL   3
`define DLQ_B_EOF    4
`define DLQ_B_OVR    5
`define DLQ_B_IDLE   6
`define DLQ_B_TXEN   3
`define DLQ_B_PRMEN  7
`define DLQ_B_BOMEN  7
`define DLQ_B_LAST   8
// reset values
`define DLQ_R_CTL    8'h00
`define DLQ_R_LEVEL  6'h20
// framing constants
`define DLQ_FLAG     8'h7E
`define DLQ_ABORT    8'hFE
`define DLQ_CRC_INIT 16'hFFFF
`define DLQ_CRC_POLY 16'h8408
`define DLQ_CRC_GOOD 16'hF0B8
`define DLQ_ALARM    16'h00FF
`define DLQ_HDR0     8'h38
`define DLQ_HDR1     8'h01
`define DLQ_HDR2     8'h03
`define DLQ_PRM_LAST 4'hA
`endif

// ---- dlq_pkg.sv ----
package dlq_pkg;
  // transmit framing states
  typedef enum logic [4:0] {
    DLQ_TX_IDLE  = 5'h01,
    DLQ_TX_OPEN  = 5'h02,
    DLQ_TX_DATA  = 5'h04,
    DLQ_TX_CRC   = 5'h08,
    DLQ_TX_CLOSE = 5'h10
  } dlq_tx_e;
  // status-of-frame byte layout
  typedef struct packed {
    logic       bad_crc;
    logic       abort;
    logic       overrun;
    logic       bad_count;
    logic [3:0] zero;
  } dlq_sf_s;
  // transmit queue entry
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } dlq_txe_s;
endpackage : dlq_pkg

// ---- dlq_link_model.sv ----
`timescale 1ns/100ps
`include "dlq_map.svh"
module dlq_link_model (
  // clock
  input  wire logic        pclk,
  // receive link into the block
  output logic             rx_bit_valid,
  output logic             rx_bit,
  // transmit link out of the block
  output logic             tx_bit_req,
  input  wire logic        tx_bit,
  // per-second report
  output logic             report_tick,
  output logic [15:0]      report_word
);
  int unsigned gap;
  int          run1;
  logic        bits[$];
  logic        txq[$];
  logic [31:0] win;
  logic        req_d;
  //////////////////////////////////////////////////////////////
  // quiet lines at time zero
  initial begin
    gap          = 0;
    run1         = 0;
    win          = 32'hFFFFFFFF;
    req_d        = 1'b0;
    rx_bit_valid = 1'b0;
    rx_bit       = 1'b0;
    tx_bit_req   = 1'b0;
    report_tick  = 1'b0;
    report_word  = 16'h0000;
  end
  // capture each bit the block hands over, one edge after the request
  always @(posedge pclk) begin
    req_d <= tx_bit_req;
    if (req_d) begin
      txq.push_back(tx_bit);
      win <= {win[30:0], tx_bit};
    end
  end
  // running check sequence, lsb first
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] v);
    for (int i = 0; i < 8; i++) c = (c[0] ^ v[i]) ? (c >> 1) ^ `DLQ_CRC_POLY : c >> 1;
    return c;
  endfunction : crc8
  // one byte lsb first, zero inserted after five ones when asked
  function automatic void add(input logic [7:0] v, input logic stuff);
    for (int i = 0; i < 8; i++) begin
      bits.push_back(v[i]);
      run1 = (stuff && v[i]) ? run1 + 1 : 0;
      if (run1 == 5) begin
        bits.push_back(1'b0);
        run1 = 0;
      end
    end
  endfunction : add
  // send the queued bits; between bits the line shows the opposite level
  task automatic drive();
    foreach (bits[i]) begin
      rx_bit_valid <= 1'b1;
      rx_bit       <= bits[i];
      @(posedge pclk);
      if (gap != 0) begin
        rx_bit_valid <= 1'b0;
        rx_bit       <= ~bits[i];
        repeat (gap) @(posedge pclk);
      end
    end
    rx_bit_valid <= 1'b0;
    rx_bit       <= ~bits[bits.size() - 1];
    bits.delete();
    @(posedge pclk);
  endtask : drive
  // flag, data, inverted check sequence, flag
  task automatic send_frame(input logic [7:0] d[$]);
    logic [15:0] crc;
    crc = `DLQ_CRC_INIT;
    add(`DLQ_FLAG, 1'b0);
    foreach (d[k]) begin
      add(d[k], 1'b1);
      crc = crc8(crc, d[k]);
    end
    crc = ~crc;
    add(crc[7:0], 1'b1);
    add(crc[15:8], 1'b1);
    add(`DLQ_FLAG, 1'b0);
    drive();
  endtask : send_frame
  // one second of report data
  task automatic tick(input logic [15:0] w);
    report_tick <= 1'b1;
    report_word <= w;
    @(posedge pclk);
    report_tick <= 1'b0;
    report_word <= ~w;
    repeat (3) @(posedge pclk);
  endtask : tick
  // take n bits, noting whether a sixteen-bit pattern went by
  task automatic pull(input int n, input logic [15:0] pat, output logic hit);
    hit = 1'b0;
    txq.delete();
    repeat (n) begin
      tx_bit_req <= 1'b1;
      @(posedge pclk);
      hit |= (win[15:0] === pat);
      if (gap != 0) begin
        tx_bit_req <= 1'b0;
        repeat (gap) @(posedge pclk);
      end
    end
    tx_bit_req <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : pull
  // first frame among captured bits: destuff, split into bytes, check
  task automatic take_frame(output logic [7:0] fr[$], output logic good);
    logic [7:0]  sh;
    logic        d[$];
    logic [15:0] crc;
    logic        open;
    logic        done;
    int          ones;
    sh   = 8'h00;
    open = 1'b0;
    done = 1'b0;
    ones = 0;
    fr   = {};
    foreach (txq[i]) begin
      sh = {txq[i], sh[7:1]};
      if (sh == `DLQ_FLAG) begin
        if (open && d.size() > 30) begin
          done = 1'b1;
          break;
        end
        open = 1'b1;
        d.delete();
        ones = 0;
      end else if (open) begin
        if (!(ones == 5 && !txq[i])) d.push_back(txq[i]);
        ones = txq[i] ? ones + 1 : 0;
      end
    end
    crc = `DLQ_CRC_INIT;
    for (int j = 0; j + 15 <= d.size(); j += 8) begin
      for (int b = 0; b < 8; b++) sh[b] = d[j + b];
      fr.push_back(sh);
      crc = crc8(crc, sh);
    end
    good = done && (crc == `DLQ_CRC_GOOD) && (fr.size() > 2);
    if (fr.size() > 1) fr = fr[0:fr.size() - 3];
  endtask : take_frame
endmodule : dlq_link_model

// ---- dlq_top_monitor.sv ----
`timescale 1ns/100ps
`include "dlq_map.svh"
module dlq_top_monitor #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // link, report, interrupt
  input wire logic        rx_bit_valid,
  input wire logic        rx_bit,
  input wire logic        tx_bit_req,
  input wire logic        tx_bit,
  input wire logic        report_tick,
  input wire logic [15:0] report_word,
  input wire logic        link_irq
);
  logic [4:0] ones_r;
  logic [7:0] sh_r;
  logic [6:0] run_r;
  logic       flag_w;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////
  // flag seen with this received bit
  assign flag_w = rx_bit_valid && ({rx_bit, sh_r[7:1]} == `DLQ_FLAG);
  // run of received ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ones_r <= 5'h00;
    else if (rx_bit_valid) ones_r <= rx_bit ? ones_r + {4'h0, ~&ones_r} : 5'h00;
  end
  // last eight bits and bits since the last flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r  <= 8'h00;
      run_r <= 7'h00;
    end else if (rx_bit_valid) begin
      sh_r  <= {rx_bit, sh_r[7:1]};
      run_r <= flag_w ? 7'h00 : run_r + {6'h00, ~&run_r};
    end
  end
  //////////////////////////////////////////////////////////////
  chk_ready_setup: assert property (psel && !penable |=> pready && penable)
    else $error("no ready in access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_rdata_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  chk_tx_hold: assert property (!tx_bit_req |=> $stable(tx_bit))
    else $error("transmit bit moved without request");
  chk_idle_irq: assert property (rx_bit_valid && rx_bit && ones_r == 5'd14 |-> ##[1:4] link_irq)
    else $error("no interrupt after fifteen ones");
  chk_eof_irq: assert property (flag_w && run_r >= 7'd30 |-> ##[1:8] link_irq)
    else $error("no interrupt after closing flag");
  cov_frame_end: cover property (flag_w && run_r >= 7'd30);
  cov_slverr: cover property (pslverr);
  cov_idle_run: cover property (ones_r == 5'd15);
endmodule : dlq_top_monitor

bind dlq_top dlq_top_monitor #(.DEPTH(DEPTH), .AW(AW)) i_mon (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .tx_bit_req(tx_bit_req), .tx_bit(tx_bit),
  .report_tick(report_tick), .report_word(report_word), .link_irq(link_irq));

// ---- tb.sv ----
`timescale 1ns/100ps
`include "dlq_map.svh"
module tb;
  localparam logic [5:0] CODE = 6'h2B;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, link_irq;
  logic        rx_bit_valid, rx_bit, tx_bit_req, tx_bit, report_tick;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] report_word, pat;
  logic        err, hit, ok;
  logic [7:0]  fr[$], q[$];
  int          errors  = 0;
  int          n_tests = 0;

  dlq_top #(.DEPTH(64), .AW(6)) i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .tx_bit_req(tx_bit_req), .tx_bit(tx_bit),
    .report_tick(report_tick), .report_word(report_word), .link_irq(link_irq));
  dlq_link_model lnk (
    .pclk(pclk), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .tx_bit_req(tx_bit_req),
    .tx_bit(tx_bit), .report_tick(report_tick), .report_word(report_word));
  //////////////////////////////////////////////////////////////
  // 250 MHz clock and overall time limit
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #300000;
    errors++;
    report_and_stop();
  end
  // counts, verdict, end of run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer: setup, then access until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      errors++;
      report_and_stop();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rdchk
  //////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values and an unmapped place
    rdchk(`DLQ_A_LEVEL, 32'h20);
    rdchk(`DLQ_A_TXCTL, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check(err, 1'b1);
    // two frames queued, slow then fast
    lnk.gap = 1;
    lnk.send_frame('{8'hA5, 8'hFF});
    lnk.gap = 0;
    lnk.send_frame('{8'h3C, 8'h7E});
    rdchk(`DLQ_A_QSTAT, 32'h83);
    rdchk(`DLQ_A_QSTAT, 32'h83);
    check(link_irq, 1'b1);
    rdchk(`DLQ_A_IRQ, 32'h10);
    q = '{8'hA5, 8'hFF, 8'h00, 8'h3C, 8'h7E, 8'h00};
    foreach (q[i]) begin
      rdchk(`DLQ_A_QSTAT, 32'h80 | (3 - i % 3));
      rdchk(`DLQ_A_RXDATA, q[i]);
    end
    rdchk(`DLQ_A_QSTAT, 32'h0);
    check(link_irq, 1'b0);
    // ones on the receive link
    repeat (16) lnk.bits.push_back(1'b1);
    lnk.drive();
    rdchk(`DLQ_A_IRQ, 32'h40);
    // long frame overruns the queue
    apb(1'b1, `DLQ_A_LEVEL, 32'h3);
    apb(1'b1, `DLQ_A_IRQEN, 32'h20);
    q.delete();
    for (int i = 0; i < 70; i++) q.push_back(8'(i));
    lnk.send_frame(q);
    check(link_irq, 1'b1);
    rdchk(`DLQ_A_QSTAT, 32'hC0);
    rdchk(`DLQ_A_IRQ, 32'h38);
    for (int i = 0; i < 63; i++) rdchk(`DLQ_A_RXDATA, i);
    apb(1'b0, `DLQ_A_RXDATA, 32'h0);
    check(rd & 32'h20, 32'h20);
    rdchk(`DLQ_A_QSTAT, 32'h0);
    lnk.send_frame('{8'h5A, 8'hC3});
    rdchk(`DLQ_A_QSTAT, 32'h83);
    // queued frame waits for the transmitter enable
    apb(1'b1, `DLQ_A_TXDATA, 32'h12);
    apb(1'b1, `DLQ_A_TXDATA, 32'h17F);
    lnk.pull(40, 16'h0, hit);
    check(lnk.win, 32'hFFFFFFFF);
    apb(1'b1, `DLQ_A_TXCTL, 32'h08);
    lnk.gap = 1;
    lnk.pull(120, 16'h0, hit);
    lnk.take_frame(fr, ok);
    check(ok, 1'b1);
    check({16'(fr.size()), fr[0], fr[1]}, {16'd2, 8'h12, 8'h7F});
    // alarm beats the bit message
    apb(1'b1, `DLQ_A_BOM, {24'h0, 2'b10, CODE});
    apb(1'b1, `DLQ_A_RALM, 32'h1);
    lnk.pull(48, 16'hFF00, hit);
    check(hit, 1'b1);
    apb(1'b1, `DLQ_A_RALM, 32'h0);
    pat = 16'hFF00;
    for (int i = 0; i < 6; i++) pat[6 - i] = CODE[i];
    lnk.pull(48, pat, hit);
    check(hit, 1'b1);
    apb(1'b1, `DLQ_A_BOM, 32'h0);
    // three seconds of report data, then a framed report
    apb(1'b1, `DLQ_A_TXCTL, 32'h88);
    for (int i = 1; i <= 3; i++) lnk.tick(16'(16'h1234 * i));
    rdchk(`DLQ_A_REPLO, 32'h9C);
    rdchk(`DLQ_A_REPHI, 32'h36);
    lnk.pull(200, 16'h0, hit);
    lnk.take_frame(fr, ok);
    check(ok, 1'b1);
    check({8'(fr.size()), fr[0], fr[1], fr[2]}, {8'd11, `DLQ_HDR0, `DLQ_HDR1, `DLQ_HDR2});
    report_and_stop();
  end
endmodule : tb
